// [hdl/output_compare_mode_unit.sv]
// output compare channel with axi4-lite register slave and interrupt
`timescale 1ns/10ps
`default_nettype none
`include "ocmp_cfg.svh"
module output_compare_mode_unit #(
	parameter int TW = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic compare_output_pin,
	output logic irq
);
	////////////////////////////////////////////////////////////////////////////
	function automatic logic [TW-1:0] merge(input logic [TW-1:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [TW-1:0] r;
		r = old;
		for (int i = 0; i < TW / 8; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic aw_held_ff, w_held_ff;
	logic [7:0] waddr_ff;
	logic [31:0] wdata_ff, rdata_ff;
	logic [3:0] wstrb_ff;
	logic [1:0] bresp_ff, rresp_ff;
	ocmp_pkg::mode_t mode_ff, last_mode_ff;
	logic trig_mode_ff, trig_ff;
	logic [TW-1:0] pri_buf_ff, sec_buf_ff, pri_act_ff, sec_act_ff;
	logic [TW-1:0] period_ff, count_ff;
	ocmp_pkg::irq_bits_t stat_ff, mask_ff;
	ocmp_pkg::phase_t phase_ff, nxt_phase;
	logic pin_ff, nxt_pin, irq_ff;

	////////////////////////////////////////////////////////////////////////////
	// write path: address and data are taken independently, applied together
	wire aw_fire = awvalid && awready_ff;
	wire w_fire = wvalid && wready_ff;
	wire wr_do = aw_held_ff && w_held_ff && !bvalid_ff;
	wire sel_ctl1 = waddr_ff == `OCMP_ADDR_CTL1;
	wire sel_ctl2 = waddr_ff == `OCMP_ADDR_CTL2;
	wire sel_pri = waddr_ff == `OCMP_ADDR_PRI;
	wire sel_sec = waddr_ff == `OCMP_ADDR_SEC;
	wire sel_per = waddr_ff == `OCMP_ADDR_PERIOD;
	wire sel_cnt = waddr_ff == `OCMP_ADDR_COUNT;
	wire sel_stat = waddr_ff == `OCMP_ADDR_IRQ_STAT;
	wire sel_mask = waddr_ff == `OCMP_ADDR_IRQ_MASK;
	wire wr_known = sel_ctl1 || sel_ctl2 || sel_pri || sel_sec || sel_per || sel_cnt
		|| sel_stat || sel_mask;
	wire wr_ctl1 = wr_do && sel_ctl1 && wstrb_ff[0];
	wire wr_ctl2 = wr_do && sel_ctl2 && wstrb_ff[0];
	wire wr_stat = wr_do && sel_stat && wstrb_ff[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'b1;
			wready_ff <= 1'b1;
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `OCMP_RESP_OKAY;
			waddr_ff <= 8'h00;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
		end else begin
			if (aw_fire) begin
				aw_held_ff <= 1'b1;
				awready_ff <= 1'b0;
				waddr_ff <= awaddr;
			end
			if (w_fire) begin
				w_held_ff <= 1'b1;
				wready_ff <= 1'b0;
				wdata_ff <= wdata;
				wstrb_ff <= wstrb;
			end
			if (wr_do) begin
				aw_held_ff <= 1'b0;
				w_held_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_known ? `OCMP_RESP_OKAY : `OCMP_RESP_SLVERR;
			end
			if (bvalid_ff && bready) begin
				bvalid_ff <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read path
	wire [15:0] ctl1_rd = {12'h000, trig_mode_ff, mode_ff};
	wire [15:0] ctl2_rd = {9'h000, trig_ff, 6'h00};
	wire [TW-1:0] zero_tw = '0;
	wire rd_known = araddr == `OCMP_ADDR_CTL1 || araddr == `OCMP_ADDR_CTL2
		|| araddr == `OCMP_ADDR_PRI || araddr == `OCMP_ADDR_SEC
		|| araddr == `OCMP_ADDR_PERIOD || araddr == `OCMP_ADDR_COUNT
		|| araddr == `OCMP_ADDR_IRQ_STAT || araddr == `OCMP_ADDR_IRQ_MASK;
	wire [TW-1:0] rd_val =
		araddr == `OCMP_ADDR_CTL1 ? TW'(ctl1_rd) :
		araddr == `OCMP_ADDR_CTL2 ? TW'(ctl2_rd) :
		araddr == `OCMP_ADDR_PRI ? pri_buf_ff :
		araddr == `OCMP_ADDR_SEC ? sec_buf_ff :
		araddr == `OCMP_ADDR_PERIOD ? period_ff :
		araddr == `OCMP_ADDR_COUNT ? count_ff :
		araddr == `OCMP_ADDR_IRQ_STAT ? TW'(stat_ff) :
		araddr == `OCMP_ADDR_IRQ_MASK ? TW'(mask_ff) : zero_tw;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= `OCMP_RESP_OKAY;
		end else if (arvalid && arready_ff) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b1;
			rdata_ff <= 32'(rd_val);
			rresp_ff <= rd_known ? `OCMP_RESP_OKAY : `OCMP_RESP_SLVERR;
		end else if (rvalid_ff && rready) begin
			rvalid_ff <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// timer and matches
	wire enabled = mode_ff != `OCMP_MODE_OFF;
	wire pwm = mode_ff == `OCMP_MODE_EDGE_PWM || mode_ff == `OCMP_MODE_CENTER_PWM;
	wire entry = mode_ff != last_mode_ff;
	wire wrap = enabled && count_ff == period_ff;
	wire cnt_zero = enabled && count_ff == zero_tw;
	wire pri_hit, sec_hit;

	compare_match #(.WIDTH(TW)) u_pri (
		.count(count_ff),
		.value(pri_act_ff),
		.enable(enabled),
		.hit(pri_hit)
	);
	compare_match #(.WIDTH(TW)) u_sec (
		.count(count_ff),
		.value(sec_act_ff),
		.enable(enabled),
		.hit(sec_hit)
	);

	// mid-period loads in pwm would shorten or double a pulse
	wire load_act = !pwm || wrap;
	wire [TW-1:0] nxt_pri_buf = wr_do && sel_pri ? merge(pri_buf_ff, wdata_ff, wstrb_ff) : pri_buf_ff;
	wire [TW-1:0] nxt_sec_buf = wr_do && sel_sec ? merge(sec_buf_ff, wdata_ff, wstrb_ff) : sec_buf_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_ff <= '0;
			period_ff <= TW'(`OCMP_PERIOD_RESET);
			pri_buf_ff <= '0;
			sec_buf_ff <= '0;
			pri_act_ff <= '0;
			sec_act_ff <= '0;
		end else begin
			pri_buf_ff <= nxt_pri_buf;
			sec_buf_ff <= nxt_sec_buf;
			if (load_act) begin
				pri_act_ff <= nxt_pri_buf;
				sec_act_ff <= nxt_sec_buf;
			end
			if (wr_do && sel_per) begin
				period_ff <= merge(period_ff, wdata_ff, wstrb_ff);
			end
			if (wr_do && sel_cnt) begin
				count_ff <= merge(count_ff, wdata_ff, wstrb_ff);
			end else if (!enabled || wrap) begin
				count_ff <= '0;
			end else begin
				count_ff <= count_ff + TW'(1);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control registers and trigger flag
	// a software write in the clear cycle wins, so a set is never lost
	wire sw_trig = wdata_ff[`OCMP_TRIG_STAT_BIT];
	wire hw_clr = trig_mode_ff && sec_hit;
	wire [2:0] nxt_mask = wr_do && sel_mask && wstrb_ff[0] ? wdata_ff[2:0] : mask_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_ff <= `OCMP_MODE_OFF;
			last_mode_ff <= `OCMP_MODE_OFF;
			trig_mode_ff <= 1'b0;
			trig_ff <= 1'b0;
			mask_ff <= '0;
		end else begin
			last_mode_ff <= mode_ff;
			if (wr_ctl1) begin
				mode_ff <= wdata_ff[`OCMP_MODE_MSB:`OCMP_MODE_LSB];
				trig_mode_ff <= wdata_ff[`OCMP_TRIG_MODE_BIT];
			end
			if (wr_ctl2) begin
				trig_ff <= sw_trig;
			end else if (hw_clr) begin
				trig_ff <= 1'b0;
			end
			mask_ff <= nxt_mask;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt status: events win over write-one-to-clear
	wire [2:0] events = {wrap, sec_hit, pri_hit};
	wire [2:0] stat_clr = wr_stat ? wdata_ff[2:0] : 3'h0;
	wire [2:0] nxt_stat = (stat_ff & ~stat_clr) | events;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat_ff <= '0;
			irq_ff <= 1'b0;
		end else begin
			stat_ff <= nxt_stat;
			irq_ff <= |(nxt_stat & nxt_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// output pin sequencing
	always_comb begin
		nxt_pin = pin_ff;
		nxt_phase = phase_ff;
		if (entry) begin
			nxt_phase = ocmp_pkg::ARM_PRI;
			case (mode_ff)
				`OCMP_MODE_SS_LOW: nxt_pin = 1'b1;
				`OCMP_MODE_SS_HIGH, `OCMP_MODE_DBL_ONCE, `OCMP_MODE_DBL_CONT,
				`OCMP_MODE_OFF: nxt_pin = 1'b0;
				default: nxt_pin = pin_ff;
			endcase
		end else begin
			case (mode_ff)
				`OCMP_MODE_SS_HIGH, `OCMP_MODE_SS_LOW: begin
					if (phase_ff == ocmp_pkg::ARM_PRI && pri_hit) begin
						nxt_pin = mode_ff == `OCMP_MODE_SS_HIGH;
						nxt_phase = ocmp_pkg::HOLD;
					end
				end
				`OCMP_MODE_TOGGLE: begin
					if (pri_hit) begin
						nxt_pin = !pin_ff;
					end
				end
				`OCMP_MODE_DBL_ONCE, `OCMP_MODE_DBL_CONT: begin
					if (phase_ff == ocmp_pkg::ARM_PRI && pri_hit) begin
						nxt_pin = !pin_ff;
						nxt_phase = ocmp_pkg::ARM_SEC;
					end else if (phase_ff == ocmp_pkg::ARM_SEC && sec_hit) begin
						nxt_pin = !pin_ff;
						nxt_phase = mode_ff == `OCMP_MODE_DBL_ONCE ? ocmp_pkg::HOLD
							: ocmp_pkg::ARM_PRI;
					end
				end
				`OCMP_MODE_EDGE_PWM: begin
					// a primary value of zero gives a flat low output
					if (pri_hit) begin
						nxt_pin = 1'b0;
					end else if (cnt_zero) begin
						nxt_pin = 1'b1;
					end
				end
				`OCMP_MODE_CENTER_PWM: begin
					if (sec_hit) begin
						nxt_pin = 1'b0;
					end else if (pri_hit) begin
						nxt_pin = 1'b1;
					end
				end
				default: nxt_pin = 1'b0;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_ff <= 1'b0;
			phase_ff <= ocmp_pkg::ARM_PRI;
		end else begin
			pin_ff <= nxt_pin;
			phase_ff <= nxt_phase;
		end
	end

	assign awready = awready_ff;
	assign wready = wready_ff;
	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign arready = arready_ff;
	assign rvalid = rvalid_ff;
	assign rdata = rdata_ff;
	assign rresp = rresp_ff;
	assign compare_output_pin = pin_ff;
	assign irq = irq_ff;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	wire steady = !entry && !wr_ctl1;
	sequence dbl_first_s;
		mode_ff == `OCMP_MODE_DBL_CONT && steady && phase_ff == ocmp_pkg::ARM_PRI && pri_hit;
	endsequence
	sequence dbl_second_s;
		##1 phase_ff == ocmp_pkg::ARM_SEC && pin_ff;
	endsequence

	trig_hw_clear_a: assert property (hw_clr && !wr_ctl2 |=> !trig_ff)
		else $error("trigger flag not cleared by secondary match");
	trig_hold_a: assert property (!trig_mode_ff && trig_ff && !wr_ctl2 |=> trig_ff)
		else $error("trigger flag cleared without software");
	center_pwm_a: assert property (mode_ff == `OCMP_MODE_CENTER_PWM && steady && pri_hit
		&& !sec_hit |=> pin_ff)
		else $error("center pwm did not rise on primary");
	edge_pwm_a: assert property (mode_ff == `OCMP_MODE_EDGE_PWM && steady && cnt_zero
		&& !pri_hit |=> pin_ff)
		else $error("edge pwm did not rise at zero");
	dbl_cont_a: assert property (dbl_first_s |-> dbl_second_s)
		else $error("double compare did not toggle high on primary");
	dbl_once_a: assert property (mode_ff == `OCMP_MODE_DBL_ONCE && steady
		&& phase_ff == ocmp_pkg::HOLD |=> $stable(pin_ff))
		else $error("single shot pulse repeated");
	toggle_each_a: assert property (mode_ff == `OCMP_MODE_TOGGLE && steady && pri_hit
		|=> pin_ff != $past(pin_ff))
		else $error("toggle mode missed a primary match");
	force_low_a: assert property (mode_ff == `OCMP_MODE_SS_LOW && steady && pri_hit
		|=> !pin_ff)
		else $error("single shot did not force low");
	force_high_a: assert property (mode_ff == `OCMP_MODE_SS_HIGH && steady && pri_hit
		|=> pin_ff)
		else $error("single shot did not force high");
	disabled_quiet_a: assert property (!enabled && !entry
		|-> !pri_hit && !sec_hit && !wrap && !pin_ff)
		else $error("disabled channel shows activity");
	pwm_buffer_a: assert property (pwm && !wrap |=> $stable(pri_act_ff)
		&& $stable(sec_act_ff))
		else $error("pwm compare value changed mid period");
	pwm_load_a: assert property (pwm && wrap |=> pri_act_ff == $past(nxt_pri_buf))
		else $error("pwm buffer not loaded at period start");
endmodule : output_compare_mode_unit
`default_nettype wire

// [hdl/ocmp_cfg.svh]
// offsets, field positions, reset values and encodings of the compare channel
// Function
// - mode select one: secondary match clears trigger
// - mode select zero: only software clears trigger
// - center pwm: high on primary, low secondary
// - edge pwm: high at zero, low primary
// - double continuous: start low, alternate toggles
// - double single shot: one pulse only
// - single compare: toggle every primary match
// - single shot high start, primary forces low
// - single shot low start, primary forces high
// - mode zero disables channel entirely
// - compare values double buffered in pwm only
`ifndef OCMP_CFG_SVH
`define OCMP_CFG_SVH
`define OCMP_ADDR_CTL1 8'h00
`define OCMP_ADDR_CTL2 8'h04
`define OCMP_ADDR_PRI 8'h08
`define OCMP_ADDR_SEC 8'h0c
`define OCMP_ADDR_PERIOD 8'h10
`define OCMP_ADDR_COUNT 8'h14
`define OCMP_ADDR_IRQ_STAT 8'h18
`define OCMP_ADDR_IRQ_MASK 8'h1c
`define OCMP_MODE_LSB 0
`define OCMP_MODE_MSB 2
`define OCMP_TRIG_MODE_BIT 3
`define OCMP_TRIG_STAT_BIT 6
`define OCMP_MODE_OFF 3'h0
`define OCMP_MODE_SS_HIGH 3'h1
`define OCMP_MODE_SS_LOW 3'h2
`define OCMP_MODE_TOGGLE 3'h3
`define OCMP_MODE_DBL_ONCE 3'h4
`define OCMP_MODE_DBL_CONT 3'h5
`define OCMP_MODE_EDGE_PWM 3'h6
`define OCMP_MODE_CENTER_PWM 3'h7
`define OCMP_EVT_PRI 0
`define OCMP_EVT_SEC 1
`define OCMP_EVT_WRAP 2
`define OCMP_PERIOD_RESET 16'hffff
`define OCMP_RESP_OKAY 2'h0
`define OCMP_RESP_SLVERR 2'h2
`endif

// [hdl/ocmp_pkg.sv]
// types shared by the compare channel files
package ocmp_pkg;
	typedef logic [2:0] mode_t;
	typedef logic [2:0] irq_bits_t;
	typedef enum {ARM_PRI, ARM_SEC, HOLD} phase_t;
endpackage : ocmp_pkg

// [hdl/compare_match.sv]
// equality comparator between the running count and one compare value
`timescale 1ns/10ps
`default_nettype none
module compare_match #(
	parameter int WIDTH = 16
) (
	input wire logic [WIDTH-1:0] count,
	input wire logic [WIDTH-1:0] value,
	input wire logic enable,
	output logic hit
);
	assign hit = enable && (count == value);
endmodule : compare_match
`default_nettype wire

// [tb/pin_load.sv]
// external load on the compare output, counting rising edges it sees
`timescale 1ns/10ps
`default_nettype none
module pin_load (
	input wire logic aclk,
	input wire logic pin,
	output var int rises_ff
);
	logic last_ff = 1'b0;
	initial rises_ff = 0;
	// a passive load: it samples only and never drives back
	always @(posedge aclk) begin
		if (pin === 1'b1 && last_ff === 1'b0) rises_ff <= rises_ff + 1;
		last_ff <= pin;
	end
endmodule : pin_load
`default_nettype wire

// [tb/test_output_compare_mode_unit.sv]
// self-checking bench for the output compare channel with a cycle model
`timescale 1ns/10ps
`default_nettype none
module test_output_compare_mode_unit;
	localparam int P = 31;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	wire logic awready, wready, bvalid, arready, rvalid, pin, irq;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	int rises, err_total = 0, check_count = 0, seed = 29, m, p;
	int m_mode, m_tsel, m_trig, m_pb, m_sb, m_pa, m_sa, m_per, m_cnt, m_pin, m_stat, m_mask;
	int m_irq, m_ent, m_ph, m_rise, pw, pa, exp_rd, np, ev_p, ev_s, ev_w, ld;
	logic [31:0] pd;
	output_compare_mode_unit i_output_compare_mode_unit (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .compare_output_pin(pin), .irq(irq));
	pin_load i_pin_load (.aclk(aclk), .pin(pin), .rises_ff(rises));
	always #5 aclk = ~aclk;
	////////////////////////////////////////////////////////////////////////////////
	function automatic int rv(input int a);
		case (a)
			8'h00: return m_tsel * 8 + m_mode;
			8'h04: return m_trig * 64;
			8'h08: return m_pb;
			8'h0c: return m_sb;
			8'h10: return m_per;
			8'h14: return m_cnt;
			8'h18: return m_stat;
			8'h1c: return m_mask;
			default: return 0;
		endcase
	endfunction : rv
	// model: values seen before the edge decide, the write lands one edge after it is taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			{m_mode, m_tsel, m_trig, m_pb, m_sb, m_pa, m_sa, m_cnt} = '0;
			{m_pin, m_stat, m_mask, m_irq, m_ent, m_ph, pw} = '0;
			m_per = 'hffff;
		end else begin
			if (arvalid && arready) exp_rd = rv(araddr);
			ev_p = m_mode != 0 && m_cnt == m_pa;
			ev_s = m_mode != 0 && m_cnt == m_sa;
			ev_w = m_mode != 0 && m_cnt == m_per;
			np = m_pin;
			if (m_ent) begin
				np = m_mode == 2 ? 1 : (m_mode == 3 || m_mode > 5) ? m_pin : 0;
				m_ph = 0;
			end else case (m_mode)
				0: np = 0;
				1: if (ev_p) np = 1;
				2: if (ev_p) np = 0;
				3: if (ev_p) np = !m_pin;
				4, 5: if (m_ph == 0 && ev_p) begin
					np = !m_pin;
					m_ph = 1;
				end else if (m_ph == 1 && ev_s) begin
					np = !m_pin;
					m_ph = m_mode == 5 ? 0 : 2;
				end
				6: if (ev_p) np = 0; else if (m_cnt == 0) np = 1;
				default: if (ev_s) np = 0; else if (ev_p) np = 1;
			endcase
			m_rise += np && !m_pin;
			m_pin = np;
			// pwm loads only at the wrap so a period never sees a half-written pair
			ld = m_mode < 6 || ev_w;
			m_cnt = m_mode == 0 ? 0 : m_cnt == m_per ? 0 : m_cnt + 1;
			if (m_tsel && ev_s) m_trig = 0;
			m_ent = 0;
			if (pw) case (pa)
				8'h00: begin
					m_ent = pd[2:0] != m_mode;
					m_mode = pd[2:0];
					m_tsel = pd[3];
				end
				8'h04: m_trig = pd[6];
				8'h08: m_pb = pd[15:0];
				8'h0c: m_sb = pd[15:0];
				8'h10: m_per = pd[15:0];
				8'h14: m_cnt = pd[15:0];
				8'h18: m_stat &= ~pd[2:0];
				8'h1c: m_mask = pd[2:0];
				default: ;
			endcase
			m_stat |= ev_w * 4 + ev_s * 2 + ev_p;
			// the active pair takes a value written in this very cycle
			if (ld) begin
				m_pa = m_pb;
				m_sa = m_sb;
			end
			m_irq = (m_stat & m_mask) != 0;
			pw = awvalid && awready && wvalid && wready;
			pa = awaddr;
			pd = wdata;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int aw, w;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'h3;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw = 0;
		w = 0;
		// no cycle limit here: only the watchdog ends a wait
		while (!(aw && w)) begin
			@(posedge aclk);
			if (awready && !aw) begin
				aw = 1;
				awvalid <= 1'b0;
			end
			if (wready && !w) begin
				w = 1;
				wvalid <= 1'b0;
			end
		end
		while (!bvalid) begin
			@(posedge aclk);
		end
		bready <= 1'b0;
		chk(bresp, er);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
		end while (!arready);
		arvalid <= 1'b0;
		do begin
			@(posedge aclk);
		end while (!rvalid);
		rready <= 1'b0;
		chk(rdata, exp_rd);
		chk(rresp, er);
	endtask : rd
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude
	////////////////////////////////////////////////////////////////////////////////
	always @(negedge aclk) begin
		if (aresetn) begin
			chk(pin, m_pin);
			chk(irq, m_irq);
		end
	end
	initial begin
		#200000;
		err_total++;
		conclude;
	end
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		for (int a = 0; a < 32; a += 4) rd(a[7:0], 2'h0);
		wr(8'h40, 32'h5, 2'h2);
		rd(8'h40, 2'h2);
		$display("test registers done");
		wr(8'h10, P, 2'h0);
		wr(8'h1c, 32'h7, 2'h0);
		for (m = 0; m < 8; m++) begin
			p = 3 + {$random(seed)} % 12;
			wr(8'h08, p, 2'h0);
			wr(8'h0c, p + 4 + {$random(seed)} % 12, 2'h0);
			// odd modes hand the flag to hardware, even ones leave it to software
			wr(8'h00, m + 8 * (m % 2), 2'h0);
			wr(8'h04, 32'h40, 2'h0);
			repeat (P * 3 / 2) @(posedge aclk);
			wr(8'h08, p + 2, 2'h0);
			repeat (P * 2) @(posedge aclk);
			rd(8'h04, 2'h0);
			rd(8'h18, 2'h0);
			wr(8'h18, 32'h7, 2'h0);
			wr(8'h1c, {$random(seed)} & 7, 2'h0);
			wr(8'h00, 32'h0, 2'h0);
			repeat (4) @(posedge aclk);
			$display("test mode %0d done", m);
		end
		chk(rises, m_rise);
		conclude;
	end
endmodule : test_output_compare_mode_unit
`default_nettype wire
